// >>> hw/cmes_defs.svh
// Constants for the count mode and edge select block.
`ifndef CMES_DEFS_SVH
`define CMES_DEFS_SVH
`define CMES_CTRL_OFFSET   8'h00
`define CMES_TC_OFFSET     8'h04
`define CMES_PC_OFFSET     8'h08
`define CMES_CTRL_RESET    8'h00
`define CMES_MODE_LSB      0
`define CMES_MODE_MSB      1
`define CMES_SEL_LSB       2
`define CMES_SEL_MSB       3
`define CMES_CLR_EN_BIT    4
`define CMES_CLR_SEL_LSB   5
`define CMES_CLR_SEL_MSB   7
`define CMES_SEL_IN0       2'h0
`define CMES_SEL_IN1       2'h2
`define CMES_CLR_RISE0     3'h0
`define CMES_CLR_FALL0     3'h1
`define CMES_CLR_RISE1     3'h4
`define CMES_CLR_FALL1     3'h5
`endif

// >>> hw/cmes_pkg.sv
// Types for the count mode and edge select block.
package cmes_pkg;
	typedef enum logic [1:0]
	{
		CMES_TIMER   = 2'h0,
		CMES_RISING  = 2'h1,
		CMES_FALLING = 2'h2,
		CMES_BOTH    = 2'h3
	} cmes_mode_t;
endpackage

// >>> hw/cmes_top.sv
// Count mode selection, edge counting and capture-clears-timer logic.
`timescale 1ns/100ps
`default_nettype none
`include "cmes_defs.svh"
module cmes_top
	import cmes_pkg::*;
#(
	parameter int WIDTH = 32
)
(
	input  wire logic             MCLK,
	input  wire logic             SRST,
	input  wire logic [7:0]       ADDR,
	input  wire logic [31:0]      WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output logic      [31:0]      RDATA,
	input  wire logic             EDGE_INPUT_ZERO,
	input  wire logic             EDGE_INPUT_ONE,
	input  wire logic [WIDTH-1:0] PRESCALE_LIMIT,
	output logic                  TIMER_TICK,
	output logic                  CLEAR_EVENT,
	output logic      [WIDTH-1:0] TIMER_COUNT_VALUE,
	output logic      [WIDTH-1:0] PRESCALE_COUNT_VALUE
);

////////////////////////////////////////////////////////////////////////////////

	// Register map: the control register holds the count mode in bits 1:0, the
	// counted pin select in bits 3:2, the clear enable in bit 4 and the clear
	// edge select in bits 7:5. The timer and prescale counts read back at their
	// own offsets and ignore writes.
	//
	// Timer mode counts every clock edge. The three counter modes count rising,
	// falling or both edges of the selected pin instead. In every mode a
	// qualifying edge advances the prescaler, and when the prescaler sits at
	// its limit the same edge wraps it to zero and advances the timer. A limit
	// of zero therefore makes every qualifying edge a timer step.
	//
	// Pins are taken as synchronous to the clock; they pass through no
	// synchroniser here. An asynchronous source needs one in front of this
	// block, and the extra latency then delays every count and clear by the
	// same amount.
	//
	// Edges are found by comparing the live pin with the sample taken at the
	// previous clock edge. A pin toggling faster than once a clock would
	// lose edges, which is why the source must hold each level for at least
	// one clock period.
	//
	// The clear path watches both pins all the time, independent of the count
	// select, so a measurement can start on one pin while the other is counted.
	// A clear in the same cycle as a count wins, and the timer restarts from
	// zero on the clearing edge itself.
	//
	// Reserved select and clear codes are stored but never count or clear.

	logic [7:0] count_control_reg;
	logic [1:0] count_input_select;
	logic       capture_clear_enable;
	logic [2:0] clear_edge_select_field;
	cmes_mode_t count_mode_field;
	logic [1:0] pin_now;
	logic [1:0] pin_prev;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;
	logic       prev_sel;
	logic       sel_now;
	logic       wrap;
	logic [31:0] read_word;
	logic [WIDTH-1:0] next_prescale;
	logic [WIDTH-1:0] next_timer;
	logic       cnt_rise;
	logic       cnt_fall;
	logic       qualify;
	logic       clear_hit;
	logic [1:0] last_select;

	assign count_mode_field        = cmes_mode_t'(count_control_reg[`CMES_MODE_MSB:`CMES_MODE_LSB]);
	assign count_input_select      = count_control_reg[`CMES_SEL_MSB:`CMES_SEL_LSB];
	assign capture_clear_enable    = count_control_reg[`CMES_CLR_EN_BIT];
	assign clear_edge_select_field = count_control_reg[`CMES_CLR_SEL_MSB:`CMES_CLR_SEL_LSB];

	// The prescaler has reached its terminal value; the next qualifying edge
	// wraps it and ticks the timer. Used by both counters and the tick pulse.
	assign wrap = PRESCALE_COUNT_VALUE >= PRESCALE_LIMIT;

////////////////////////////////////////////////////////////////////////////////

	// Low to high between two consecutive samples of one pin.
	function automatic logic edge_rise
	(
		input logic now_s,
		input logic prev_s
	);
		return now_s && !prev_s;
	endfunction

	// High to low between two consecutive samples of one pin.
	function automatic logic edge_fall
	(
		input logic now_s,
		input logic prev_s
	);
		return !now_s && prev_s;
	endfunction

	// Only the two documented select codes name a pin; the reserved ones count
	// nothing rather than aliasing onto a pin that software did not ask for.
	function automatic logic select_valid
	(
		input logic [1:0] sel
	);
		return sel == `CMES_SEL_IN0 || sel == `CMES_SEL_IN1;
	endfunction

	// Maps a clear select code to the edge that clears; reserved codes never
	// clear, so a stray write there cannot wipe a running measurement.
	function automatic logic clear_decode
	(
		input logic [2:0] code,
		input logic [1:0] rise,
		input logic [1:0] fall
	);
		case (code)
			`CMES_CLR_RISE0: return rise[0];
			`CMES_CLR_FALL0: return fall[0];
			`CMES_CLR_RISE1: return rise[1];
			`CMES_CLR_FALL1: return fall[1];
			default:         return 1'b0;
		endcase
	endfunction

////////////////////////////////////////////////////////////////////////////////

	// Reserved upper bits are not stored and read as zero.
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			count_control_reg <= `CMES_CTRL_RESET;
		else if (WR && ADDR == `CMES_CTRL_OFFSET)
			count_control_reg <= WDATA[7:0];
	end

	// The read word is chosen combinationally and registered, so read data
	// stand for exactly the cycle after the strobe and are zero otherwise.
	always_comb
	begin
		read_word = 32'h0;
		if (RD)
		begin
			case (ADDR)
				`CMES_CTRL_OFFSET: read_word = {24'h0, count_control_reg};
				`CMES_TC_OFFSET:   read_word = 32'(TIMER_COUNT_VALUE);
				`CMES_PC_OFFSET:   read_word = 32'(PRESCALE_COUNT_VALUE);
				default:           read_word = 32'h0;
			endcase
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			RDATA <= 32'h0;
		else
			RDATA <= read_word;
	end

////////////////////////////////////////////////////////////////////////////////

	assign pin_now = {EDGE_INPUT_ONE, EDGE_INPUT_ZERO};

	// Both pins are sampled every edge so the clear logic sees edges in any mode.
	// During reset the previous sample follows the live pin, so the first edge
	// after release cannot report a level change that never happened.
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_pin
			always_ff @(posedge MCLK)
			begin
				if (SRST)
					pin_prev[i] <= pin_now[i];
				else
					pin_prev[i] <= pin_now[i];
			end

			assign pin_rise[i] = edge_rise(pin_now[i], pin_prev[i]);
			assign pin_fall[i] = edge_fall(pin_now[i], pin_prev[i]);
		end
	endgenerate

	// Reserved select codes count nothing.
	assign sel_now = (count_input_select == `CMES_SEL_IN1) ? EDGE_INPUT_ONE : EDGE_INPUT_ZERO;

	// The counted sample follows the selected pin every clock; a switch of pins
	// is masked for one cycle by last_select, so it is never taken for an edge.
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			prev_sel <= EDGE_INPUT_ZERO;
		else
			prev_sel <= sel_now;
	end

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			last_select <= `CMES_SEL_IN0;
		else
			last_select <= count_input_select;
	end

	// The one-cycle blackout after a select change costs at most one edge of
	// the new pin; the pin rules already forbid edges closer than one clock.
	always_comb
	begin
		cnt_rise = 1'b0;
		cnt_fall = 1'b0;
		if (last_select == count_input_select && select_valid(count_input_select))
		begin
			cnt_rise = edge_rise(sel_now, prev_sel);
			cnt_fall = edge_fall(sel_now, prev_sel);
		end
	end

	always_comb
	begin
		case (count_mode_field)
			CMES_TIMER:   qualify = 1'b1;
			CMES_RISING:  qualify = cnt_rise;
			CMES_FALLING: qualify = cnt_fall;
			CMES_BOTH:    qualify = cnt_rise || cnt_fall;
			default:      qualify = 1'b0;
		endcase
	end

	// With the enable low the select field is ignored, so software may set up
	// the edge first and arm the clear afterwards without a spurious clear.
	always_comb
	begin
		clear_hit = 1'b0;
		if (capture_clear_enable)
			clear_hit = clear_decode(clear_edge_select_field, pin_rise, pin_fall);
	end

////////////////////////////////////////////////////////////////////////////////

	// Next values of both counters. A clear wins over a count in the same cycle
	// so a measurement always restarts from zero on the chosen edge.
	always_comb
	begin
		next_prescale = PRESCALE_COUNT_VALUE;
		next_timer    = TIMER_COUNT_VALUE;
		if (clear_hit)
		begin
			next_prescale = '0;
			next_timer    = '0;
		end
		else if (qualify)
		begin
			if (wrap)
			begin
				next_prescale = '0;
				next_timer    = TIMER_COUNT_VALUE + 1'b1;
			end
			else
				next_prescale = PRESCALE_COUNT_VALUE + 1'b1;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			PRESCALE_COUNT_VALUE <= '0;
		else
			PRESCALE_COUNT_VALUE <= next_prescale;
	end

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			TIMER_COUNT_VALUE <= '0;
		else
			TIMER_COUNT_VALUE <= next_timer;
	end

	// The tick marks a timer step, so it stays low when a clear took the edge.
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			TIMER_TICK <= 1'b0;
		else
			TIMER_TICK <= qualify && !clear_hit && wrap;
	end

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			CLEAR_EVENT <= 1'b0;
		else
			CLEAR_EVENT <= clear_hit;
	end

endmodule // cmes_top
`default_nettype wire

// >>> tb/cmes_chk.sv
// Assertion checker for the count mode and edge select block.
`timescale 1ns/100ps
`default_nettype none
module cmes_chk #(parameter int WIDTH = 32)
(
	input wire logic		MCLK,
	input wire logic		SRST,
	input wire logic [7:0]		ADDR,
	input wire logic [31:0]		WDATA,
	input wire logic		WR,
	input wire logic		RD,
	input wire logic [31:0]		RDATA,
	input wire logic		EDGE_INPUT_ZERO,
	input wire logic		EDGE_INPUT_ONE,
	input wire logic		TIMER_TICK,
	input wire logic		CLEAR_EVENT,
	input wire logic [WIDTH-1:0]	TIMER_COUNT_VALUE,
	input wire logic [WIDTH-1:0]	PRESCALE_LIMIT,
	input wire logic [WIDTH-1:0]	PRESCALE_COUNT_VALUE
);
	logic [7:0]	c;
	logic [1:0]	p;
	wire logic [1:0] v = {EDGE_INPUT_ONE, EDGE_INPUT_ZERO};
	wire logic	s = v[c[3]];
	wire logic	q = p[c[3]];
	wire logic	h = !c[2] && (c[0] && s && !q || c[1] && !s && q);
	wire logic	x = c[4] && !c[6] && (c[5] ? p[c[7]] && !v[c[7]] : v[c[7]] && !p[c[7]]);
	// A shadow of the control field, so each check knows the programmed mode.
	always_ff @(posedge MCLK)
	begin
		p <= v;
		c <= SRST ? 8'h00 : (WR && ADDR == 8'h00) ? WDATA[7:0] : c;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	property p_rst; $fell(SRST) |-> TIMER_COUNT_VALUE == 0; endproperty
	a_rst: assert property (p_rst) else $error("count not zero");
	property p_ctl; RD && ADDR == 8'h00 |=> RDATA == {24'h0, c}; endproperty
	a_ctl: assert property (p_ctl) else $error("control readback");
	property p_rd; !$past(RD) |-> RDATA == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("idle read data");
	property p_tim; c[1:0] == 2'h0 && !c[4] |=> TIMER_COUNT_VALUE == $past(TIMER_COUNT_VALUE)
		+ ($past(PRESCALE_COUNT_VALUE) >= $past(PRESCALE_LIMIT)); endproperty
	a_tim: assert property (p_tim) else $error("timer step");
	property p_pre; c[1:0] == 2'h0 && !c[4] |=> PRESCALE_COUNT_VALUE ==
		($past(PRESCALE_COUNT_VALUE) >= $past(PRESCALE_LIMIT) ? '0 : $past(PRESCALE_COUNT_VALUE) + 1);
	endproperty
	a_pre: assert property (p_pre) else $error("prescale step");
	property p_cnt; c[1:0] != 2'h0 && !c[4] && $stable(c[3:2])
		|=> TIMER_COUNT_VALUE == $past(TIMER_COUNT_VALUE) + $past(h); endproperty
	a_cnt: assert property (p_cnt) else $error("edge count");
	property p_tck; TIMER_TICK |-> TIMER_COUNT_VALUE == $past(TIMER_COUNT_VALUE) + 1; endproperty
	a_tck: assert property (p_tck) else $error("tick without step");
	property p_clr; x |=> CLEAR_EVENT && TIMER_COUNT_VALUE == 0; endproperty
	a_clr: assert property (p_clr) else $error("clear missed");
	property p_src; CLEAR_EVENT |-> $past(x); endproperty
	a_src: assert property (p_src) else $error("stray clear");
	c_clr: cover property (CLEAR_EVENT);
	c_both: cover property (TIMER_TICK && c[1:0] == 2'h3);
	c_rd: cover property (RD && ADDR == 8'h04);
endmodule // cmes_chk
bind cmes_top cmes_chk #(.WIDTH(WIDTH)) u_chk (.MCLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.EDGE_INPUT_ZERO, .EDGE_INPUT_ONE, .TIMER_TICK, .CLEAR_EVENT, .TIMER_COUNT_VALUE,
	.PRESCALE_LIMIT, .PRESCALE_COUNT_VALUE);
`default_nettype wire

// >>> tb/cmes_src.sv
// Model of the sources on the two edge inputs.
`timescale 1ns/100ps
`default_nettype none
module cmes_src
(
	input wire logic	k,
	input wire logic [1:0]	f,
	output logic		z = 1'b0,
	output logic		o = 1'b0
);
	// At most one toggle a clock, so no level is shorter than a period.
	always @(posedge k)
	begin
		z <= z ^ f[0];
		o <= o ^ f[1];
	end
endmodule // cmes_src
`default_nettype wire

// >>> tb/tb.sv
// Testbench for the count mode and edge select block.
`timescale 1ns/100ps
`default_nettype none
module tb import cmes_pkg::*;;
	logic		k = 1'b0, r = 1'b1, wr = 1'b0, rd = 1'b0, z, o, c, tk;
	logic [7:0]	a = 8'h00;
	logic [31:0]	w = 32'h0, q, t, d, b, l = 32'h0, pc;
	logic [1:0]	f = 2'h0;
	int		fail_count = 0, total_checks = 0, n = 0, e = 0, g = 0, y;
	always #12.5 k = ~k;
	cmes_top DUT (.MCLK(k), .SRST(r), .ADDR(a), .WDATA(w), .WR(wr), .RD(rd), .RDATA(q),
		.EDGE_INPUT_ZERO(z), .EDGE_INPUT_ONE(o), .PRESCALE_LIMIT(l), .TIMER_TICK(tk),
		.CLEAR_EVENT(c), .TIMER_COUNT_VALUE(t), .PRESCALE_COUNT_VALUE(pc));
	cmes_src src (.k(k), .f(f), .z(z), .o(o));
	always @(posedge k)
	begin
		n <= n + 1;
		e <= e + (c === 1'b1);
		g <= g + (tk === 1'b1);
		if (n == 2000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////
	task ck(input logic [31:0] s, x, input string m);
		total_checks++;
		if (s !== x)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", m, x, s);
		end
	endtask
	task bus(input logic iw, input logic [7:0] ad, input logic [31:0] dw, output logic [31:0] v);
		@(posedge k);
		a <= ad;
		w <= dw;
		{wr, rd} <= {iw, !iw};
		@(posedge k);
		{wr, rd} <= 2'h0;
		#1 v = q;
	endtask
	task tg(input logic [1:0] m, input int j);
		repeat (j)
		begin
			@(posedge k);
			f <= m;
			@(posedge k);
			f <= 2'h0;
		end
		repeat (3) @(posedge k);
	endtask
	task t_reg;
		bus(0, 8'h00, 0, d);
		ck(d, 32'h0, "reset ctrl");
		bus(1, 8'h00, 32'hF1, d);
		bus(0, 8'h00, 0, d);
		ck(d, 32'hF1, "ctrl");
		bus(0, 8'h40, 0, d);
		ck(d, 32'h0, "unmapped");
		$display("t_reg done");
	endtask
	task t_tim;
		bus(1, 8'h00, 32'h0, d);
		b = t;
		repeat (10) @(posedge k);
		#1 ck(t, b + 32'h0A, "timer");
		$display("t_tim done");
	endtask
	task t_cnt;
		for (int m = 1; m < 4; m++)
			for (int s = 0; s < 3; s++)
			begin
				bus(1, 8'h00, 32'(m + 4 * s), d);
				bus(0, 8'h04, 0, b);
				tg(2'h3, 4);
				tg(s == 2 ? 2'h1 : 2'h2, 2);
				bus(0, 8'h04, 0, d);
				ck(d - b, s == 1 ? 32'h0 : m == CMES_BOTH ? 32'h4 : 32'h2, "count");
			end
		$display("t_cnt done");
	endtask
	task t_clr;
		for (int j = 0; j < 9; j++)
		begin
			bus(1, 8'h00, j < 8 ? 32'(16 + 32 * j) : 32'h20, d);
			y = e;
			tg(2'h3, 2);
			ck(32'(e - y), 32'(j % 4 < 2 && j < 8), "clear");
			if (j % 4 < 2 && j < 8)
				ck(32'(t < 32'h10), 32'h1, "zeroed");
		end
		$display("t_clr done");
	endtask
	task t_pre;
		l <= 32'h3;
		bus(1, 8'h00, 32'h0, d);
		b = t;
		y = g;
		repeat (8) @(posedge k);
		#1 ck(t, b + 32'h2, "prescaled timer");
		ck(32'(pc < 32'h4), 32'h1, "prescale range");
		ck(32'(g - y), 32'h2, "tick count");
		l <= 32'h0;
		$display("t_pre done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge k);
		r <= 1'b0;
		t_reg();
		t_tim();
		t_cnt();
		t_clr();
		t_pre();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
